/* File: pin_world.sv */
`timescale 1ns/1ps
module pin_world (
   input wire logic [31:0] pin_out, // Device drive values
   input wire logic [31:0] pin_oe_n, // Device drive enables, low drives
   input wire logic [31:0] ext_val, // Board drive where the device releases
   output logic [31:0] pin_in // Resolved pin levels
);
   // The board never contends: it drives only pins that the device has released
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
endmodule : pin_world

/* File: port_d_data.sv */
`timescale 1ns/1ps
// How it works
// R1: 16-bit upper register maps pins 31..16
// R2: output port pins drive their register bit
// R3: output pins read back register bit
// R4: input pins read back sampled pin level
// R5: input pin writes store but never drive
// R6: power-on reset clears both data registers
// R7: no other reset or sleep clears them
// R8: small package: register works, no pins
// R9: upper register decoded, all access sizes
// R10: lower register decoded, all access sizes
// R11: mode selects bus, port or alternate
// R12: other functions: direction picks read source
// R13: byte access touches only its lane
module port_d_data
   import port_d_pkg::*;
#(
   parameter bit WIDE_PACKAGE = 1'b1
) (
   input wire logic pclk, // 25 MHz bus clock
   input wire logic presetn, // Power-on reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [ADDR_W-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [1:0] mode_pins, // Operating mode strap
   input wire logic [31:0] pin_in, // Pin levels
   output logic [31:0] pin_out, // Pin drive values
   output logic [31:0] pin_oe_n, // Pin drive enables, low drives
   input wire logic [31:0] func_out, // Bus or alternate drive values
   input wire logic [31:0] func_drive, // Bus or alternate drive requests
   output logic [31:0] pin_level, // Synchronised pin levels
   output logic [31:0] port_owned // High where a pin acts as port
);
   logic [31:0] pin_meta_reg, pin_sync_reg;
   logic [1:0] mode_meta_reg, mode_sync_reg;
   logic [1:0] settle_reg, settle_next;
   logic done_reg, done_next;
   mode_e mode_reg, mode_next;
   logic [15:0] upper_reg, upper_next, lower_reg, lower_next;
   logic [31:0] dir_reg, dir_next;
   func_s func_reg, func_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [31:0] pin_out_reg, pin_out_next, oe_n_reg, oe_n_next;
   role_e role [32];
   logic [31:0] port_vec, drive_vec, other_vec, port_rd;
   logic setup, access, wr, hit_upper, hit_lower, hit_dir, hit_func, hit_stat, hit;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                           input logic [1:0] strb);
      merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   // Pins and strap cross in through two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_reg <= 32'h00000000;
         pin_sync_reg <= 32'h00000000;
         mode_meta_reg <= 2'h0;
         mode_sync_reg <= 2'h0;
      end else begin
         pin_meta_reg <= pin_in;
         pin_sync_reg <= pin_meta_reg;
         mode_meta_reg <= mode_pins;
         mode_sync_reg <= mode_meta_reg;
      end
   end

   // Strap is caught once, after the synchroniser has filled
   always_comb begin
      settle_next = settle_reg;
      done_next = done_reg;
      mode_next = mode_reg;
      if (!done_reg) begin
         if (settle_reg == STRAP_SETTLE) begin
            done_next = 1'b1;
            case (mode_sync_reg)
               2'h0: mode_next = MODE_EXT0;
               2'h1: mode_next = MODE_EXT1;
               2'h2: mode_next = MODE_EXT2;
               default: mode_next = MODE_SINGLE;
            endcase
         end else begin
            settle_next = settle_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_reg <= 2'h0;
         done_reg <= 1'b0;
         mode_reg <= MODE_EXT0;
      end else begin
         settle_reg <= settle_next;
         done_reg <= done_next;
         mode_reg <= mode_next;
      end
   end

   // Pin role by mode
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         role[i] = ROLE_PORT;
         role[i+16] = ROLE_PORT;
         case (mode_reg)
            MODE_EXT1: begin // R11
               role[i] = ROLE_BUS;
               role[i+16] = ROLE_BUS;
            end
            MODE_EXT0, MODE_EXT2: begin // R11
               if (mode_reg == MODE_EXT0 || func_reg.lower_bus)
                  role[i] = ROLE_BUS;
               if (func_reg.upper_bus)
                  role[i+16] = ROLE_BUS;
               else if (func_reg.alt[i])
                  role[i+16] = ROLE_ALT;
            end
            MODE_SINGLE: begin // R11
               if (func_reg.alt[i] && ALT_SINGLE_MASK[i])
                  role[i+16] = ROLE_ALT;
            end
            default: role[i] = ROLE_PORT;
         endcase
      end
   end

   always_comb begin
      for (int i = 0; i < 32; i++) begin
         port_vec[i] = (role[i] == ROLE_PORT);
      end
      drive_vec = port_vec & dir_reg;
      other_vec = ~port_vec & func_drive;
      if (!done_reg) begin
         drive_vec = 32'h00000000;
         other_vec = 32'h00000000;
      end
      if (!WIDE_PACKAGE) begin // R8
         drive_vec[31:16] = 16'h0000;
         other_vec[31:16] = 16'h0000;
      end
      // Read source follows direction for port and other roles alike
      port_rd = (dir_reg & {upper_reg, lower_reg}) | (~dir_reg & pin_sync_reg); // R3 R4 R12
      if (!WIDE_PACKAGE)
         port_rd[31:16] = upper_reg; // R8
   end

   // Pin drivers: port pins from the register, others from their function
   always_comb begin
      pin_out_next = (drive_vec & {upper_reg, lower_reg}) | (other_vec & func_out); // R2 R12
      oe_n_next = ~(drive_vec | other_vec); // R5
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_reg <= 32'h00000000;
         oe_n_reg <= 32'hFFFFFFFF;
      end else begin
         pin_out_reg <= pin_out_next;
         oe_n_reg <= oe_n_next;
      end
   end

   // APB slave, no wait states
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hit_upper = (paddr == ADDR_UPPER); // R9
   assign hit_lower = (paddr == ADDR_LOWER); // R10
   assign hit_dir = (paddr == ADDR_DIR);
   assign hit_func = (paddr == ADDR_FUNC);
   assign hit_stat = (paddr == ADDR_STAT);
   assign hit = hit_upper || hit_lower || hit_dir || hit_func || hit_stat;
   assign wr = access && pwrite;

   always_comb begin
      upper_next = upper_reg;
      lower_next = lower_reg;
      dir_next = dir_reg;
      func_next = func_reg;
      prdata_next = prdata_reg;
      if (wr && hit_upper)
         upper_next = merge16(upper_reg, pwdata[15:0], pstrb[1:0]); // R1 R5 R13
      if (wr && hit_lower)
         lower_next = merge16(lower_reg, pwdata[15:0], pstrb[1:0]); // R13
      if (wr && hit_dir) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b])
               dir_next[b*8 +: 8] = pwdata[b*8 +: 8];
         end
      end
      if (wr && hit_func) begin
         func_next.alt = merge16(func_reg.alt, pwdata[15:0], pstrb[1:0]);
         if (pstrb[2]) begin
            func_next.upper_bus = pwdata[FUNC_UPPER_BUS_BIT];
            func_next.lower_bus = pwdata[FUNC_LOWER_BUS_BIT];
         end
      end
      if (setup && !pwrite) begin
         prdata_next = 32'h00000000;
         if (hit_upper)
            prdata_next[15:0] = port_rd[31:16]; // R3 R4
         if (hit_lower)
            prdata_next[15:0] = port_rd[15:0];
         if (hit_dir)
            prdata_next = dir_reg;
         if (hit_func)
            prdata_next[17:0] = func_reg;
         if (hit_stat) begin
            prdata_next[STAT_MODE_LSB +: 2] = mode_reg;
            prdata_next[STAT_WIDE_BIT] = WIDE_PACKAGE;
            prdata_next[STAT_DONE_BIT] = done_reg;
         end
      end
   end

   // Only power-on reset clears these; no other reset reaches them
   always_ff @(posedge pclk or negedge presetn) begin // R7
      if (!presetn) begin
         upper_reg <= DATA_RESET; // R6
         lower_reg <= DATA_RESET; // R6
         dir_reg <= DIR_RESET;
         func_reg <= '{lower_bus: 1'b0, upper_bus: 1'b0, alt: ALT_RESET};
         prdata_reg <= 32'h00000000;
      end else begin
         upper_reg <= upper_next;
         lower_reg <= lower_next;
         dir_reg <= dir_next;
         func_reg <= func_next;
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = access && !hit; // R9 R10
   assign pin_out = pin_out_reg;
   assign pin_oe_n = oe_n_reg;
   assign pin_level = pin_sync_reg;
   assign port_owned = port_vec;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_read_setup(h);
      psel && !penable && !pwrite && h;
   endsequence

   sequence s_write_access(h);
      psel && penable && pwrite && h;
   endsequence

   property p_port_drive;
      1 |=> (((pin_out ^ $past({upper_reg, lower_reg})) & $past(drive_vec)) == 32'h0)
            && ((pin_oe_n & $past(drive_vec)) == 32'h0);
   endproperty
   a_port_drive: assert property (p_port_drive) // R2
      else $error("output port pin not driving its register bit");

   property p_read_output;
      s_read_setup(hit_upper) ##1 (psel && penable)
         |-> ((prdata[15:0] ^ $past(upper_reg)) & $past(dir_reg[31:16])) == 16'h0;
   endproperty
   a_read_output: assert property (p_read_output) // R3
      else $error("output pin read did not return register bit");

   property p_read_input;
      s_read_setup(hit_lower) ##1 (psel && penable)
         |-> ((prdata[15:0] ^ $past(pin_sync_reg[15:0])) & ~$past(dir_reg[15:0])) == 16'h0;
   endproperty
   a_read_input: assert property (p_read_input) // R4
      else $error("input pin read did not return pin level");

   property p_input_released;
      1 |=> ($past(port_vec & ~dir_reg) & ~pin_oe_n) == 32'h0;
   endproperty
   a_input_released: assert property (p_input_released) // R5
      else $error("input port pin is being driven");

   property p_write_stores;
      s_write_access(hit_upper && pstrb[1:0] == 2'h3) |=> upper_reg == $past(pwdata[15:0]);
   endproperty
   a_write_stores: assert property (p_write_stores) // R1
      else $error("upper register did not store written value");

   property p_power_on_clear;
      @(posedge pclk) disable iff (1'b0)
         !presetn |-> upper_reg == DATA_RESET && lower_reg == DATA_RESET;
   endproperty
   a_power_on_clear: assert property (p_power_on_clear) // R6
      else $error("data registers not cleared by power-on reset");

   property p_hold;
      !(psel && penable && pwrite) |=> $stable(upper_reg) && $stable(lower_reg);
   endproperty
   a_hold: assert property (p_hold) // R7
      else $error("data register changed without a write");

   property p_small_package;
      !WIDE_PACKAGE |-> pin_oe_n[31:16] == 16'hFFFF;
   endproperty
   a_small_package: assert property (p_small_package) // R8
      else $error("missing upper pins are driven");

   property p_decode;
      psel && penable |-> pslverr == !(hit_upper || hit_lower || hit_dir || hit_func || hit_stat);
   endproperty
   a_decode: assert property (p_decode) // R9
      else $error("wrong error answer for address");

   property p_mode_bus;
      done_reg && mode_reg == MODE_EXT1 |=> pin_oe_n == (~$past(func_drive) | (WIDE_PACKAGE ?
         32'h0 : 32'hFFFF0000));
   endproperty
   a_mode_bus: assert property (p_mode_bus) // R11
      else $error("data bus mode not handing pins to the bus");

   property p_other_drive;
      1 |=> ((pin_out ^ $past(func_out)) & $past(other_vec)) == 32'h0;
   endproperty
   a_other_drive: assert property (p_other_drive) // R12
      else $error("register value reached a pin owned by another function");

   property p_byte_lane;
      s_write_access(hit_upper && pstrb[1:0] == 2'h1)
         |=> upper_reg[15:8] == $past(upper_reg[15:8]);
   endproperty
   a_byte_lane: assert property (p_byte_lane) // R13
      else $error("byte write changed the other lane");

   // A write to the top lane alone leaves the bottom lane as it was
   property p_byte_lane_low;
      s_write_access(hit_upper && pstrb[1:0] == 2'h2)
         |=> upper_reg[7:0] == $past(upper_reg[7:0]);
   endproperty
   a_byte_lane_low: assert property (p_byte_lane_low) // R13
      else $error("top lane write changed the bottom lane");
endmodule : port_d_data

/* File: port_d_pkg.sv */
package port_d_pkg;
   localparam int ADDR_W = 12;
   // Printed offsets are register indexes; byte address is four times the index
   localparam logic [31:0] IDX_UPPER = 32'hFFFF83A0;
   localparam logic [31:0] IDX_LOWER = 32'hFFFF83A2;
   localparam logic [31:0] IDX_DIR = 32'hFFFF83A4;
   localparam logic [31:0] IDX_FUNC = 32'hFFFF83A6;
   localparam logic [31:0] IDX_STAT = 32'hFFFF83A8;
   localparam logic [ADDR_W-1:0] ADDR_UPPER = ADDR_W'(IDX_UPPER << 2);
   localparam logic [ADDR_W-1:0] ADDR_LOWER = ADDR_W'(IDX_LOWER << 2);
   localparam logic [ADDR_W-1:0] ADDR_DIR = ADDR_W'(IDX_DIR << 2);
   localparam logic [ADDR_W-1:0] ADDR_FUNC = ADDR_W'(IDX_FUNC << 2);
   localparam logic [ADDR_W-1:0] ADDR_STAT = ADDR_W'(IDX_STAT << 2);
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [31:0] DIR_RESET = 32'h00000000;
   localparam logic [15:0] ALT_RESET = 16'h0000;
   // Upper pins that keep an alternate function in single-chip mode
   localparam logic [15:0] ALT_SINGLE_MASK = 16'hC0FF;
   localparam int FUNC_ALT_LSB = 0;
   localparam int FUNC_UPPER_BUS_BIT = 16;
   localparam int FUNC_LOWER_BUS_BIT = 17;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_WIDE_BIT = 2;
   localparam int STAT_DONE_BIT = 3;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   typedef enum logic [1:0] {MODE_EXT0, MODE_EXT1, MODE_EXT2, MODE_SINGLE} mode_e;
   typedef enum logic [1:0] {ROLE_PORT, ROLE_BUS, ROLE_ALT} role_e;
   typedef struct packed {
      logic lower_bus;
      logic upper_bus;
      logic [15:0] alt;
   } func_s;
endpackage : port_d_pkg

/* File: port_d_upper_data_register_tb_top.sv */
`timescale 1ns/1ps
module port_d_upper_data_register_tb_top;
   import port_d_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, small_prdata, rd, small_rd, ext_val, port_owned;
   logic [31:0] pin_in, pin_out, pin_oe_n, small_in, small_out, small_oe_n;
   logic [31:0] func_out, func_drive, pin_level;
   logic [3:0] pstrb;
   logic [1:0] mode_pins;
   int err_count = 0;
   int tests_run = 0;
   logic [31:0] owned_exp [4] = '{32'hFFFF0000, 32'h00000000, 32'hFFFFFFFF, 32'hFFFFFFFF};

   port_d_data DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mode_pins(mode_pins), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .func_out(func_out), .func_drive(func_drive),
      .pin_level(pin_level), .port_owned(port_owned));
   port_d_data #(.WIDE_PACKAGE(1'b0)) dut_small (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(small_prdata), .pready(), .pslverr(), .mode_pins(mode_pins), .pin_in(small_in),
      .pin_out(small_out), .pin_oe_n(small_oe_n), .func_out(func_out),
      .func_drive(func_drive), .pin_level(), .port_owned());
   pin_world board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .pin_in(pin_in));
   pin_world board_small (.pin_out(small_out), .pin_oe_n(small_oe_n), .ext_val(ext_val),
      .pin_in(small_in));

   task automatic summarize();
      if (err_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Entered right after a rising edge; returns right after one
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
         input logic [3:0] s);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         err_count++;
         summarize();
      end
      rd = prdata;
      small_rd = small_prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic reset_dut(input logic [1:0] m);
      mode_pins <= m;
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask : reset_dut

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      mode_pins = 2'h3;
      func_out = '0;
      func_drive = '0;
      ext_val = '0;
      reset_dut(2'h3);
      apb(1'b1, ADDR_DIR, 32'hFFFFFFFF, 4'hF);
      apb(1'b0, ADDR_UPPER, '0, 4'h0);
      chk("upper after reset", 32'h0, rd);
      apb(1'b0, ADDR_LOWER, '0, 4'h0);
      chk("lower after reset", 32'h0, rd);
      ext_val <= 32'h5A3C0000;
      apb(1'b1, ADDR_UPPER, 32'hFFFFA5C3, 4'hF);
      repeat (4) @(posedge pclk);
      chk("upper pin drive", 32'hA5C3, {16'h0, pin_out[31:16]});
      chk("upper pin enable", 32'h0, {16'h0, pin_oe_n[31:16]});
      // Pin 16 to its alternate with no request: the board pulls it to 0
      apb(1'b1, ADDR_FUNC, 32'h1, 4'h3);
      repeat (4) @(posedge pclk);
      chk("alternate pin released", 32'h1, {31'h0, pin_oe_n[16]});
      apb(1'b0, ADDR_UPPER, '0, 4'h0);
      chk("upper read of outputs", 32'hA5C3, rd);
      apb(1'b1, ADDR_UPPER, 32'h00003C00, 4'h2);
      apb(1'b0, ADDR_UPPER, '0, 4'h0);
      chk("byte lane write", 32'h3CC3, rd);
      chk("small package read", 32'h3CC3, small_rd);
      chk("small package pins", 32'hFFFF, {16'h0, small_oe_n[31:16]});
      apb(1'b1, ADDR_UPPER, 32'h000000AA, 4'h1);
      apb(1'b0, ADDR_UPPER, '0, 4'h0);
      chk("bottom lane write", 32'h3CAA, rd);
      apb(1'b1, ADDR_LOWER, 32'h00001234, 4'h3);
      repeat (4) @(posedge pclk);
      chk("lower pin drive", 32'h1234, {16'h0, pin_out[15:0]});
      apb(1'b0, ADDR_LOWER, '0, 4'h0);
      chk("lower read", 32'h1234, rd);
      apb(1'b1, ADDR_DIR, 32'h0000FFFF, 4'hF);
      ext_val <= 32'h96690000;
      apb(1'b1, ADDR_UPPER, 32'h0000FFFF, 4'h3);
      repeat (4) @(posedge pclk);
      chk("input pins undriven", 32'hFFFF, {16'h0, pin_oe_n[31:16]});
      chk("synchronised pin level", 32'h9669, {16'h0, pin_level[31:16]});
      apb(1'b0, ADDR_UPPER, '0, 4'h0);
      chk("input read of pins", 32'h9669, rd);
      apb(1'b1, ADDR_DIR, 32'hFFFFFFFF, 4'hF);
      apb(1'b0, ADDR_UPPER, '0, 4'h0);
      chk("stored while input", 32'hFFFF, rd);
      apb(1'b1, ADDR_DIR, 32'h00000000, 4'hF);
      repeat (4) @(posedge pclk);
      apb(1'b0, ADDR_LOWER, '0, 4'h0);
      chk("lower input read of pins", 32'h0, rd);
      apb(1'b0, 12'h004, '0, 4'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped read", 32'h0, rd);
      func_out <= 32'h5AA5C33C;
      func_drive <= 32'hFFFFFFFF;
      for (int m = 0; m < 4; m++) begin
         reset_dut(2'(m));
         chk("port ownership", owned_exp[m], port_owned);
         chk("pin enables by mode", owned_exp[m], pin_oe_n);
         chk("function drive", 32'h5AA5C33C & ~owned_exp[m], pin_out & ~owned_exp[m]);
         apb(1'b0, ADDR_STAT, '0, 4'h0);
         chk("mode status", 32'hC | m, rd);
      end
      reset_dut(2'h2);
      apb(1'b1, ADDR_FUNC, 32'h00030000, 4'h4);
      repeat (4) @(posedge pclk);
      chk("bus select ownership", 32'h0, port_owned);
      chk("bus select enables", 32'h0, pin_oe_n);
      summarize();
   end
endmodule : port_d_upper_data_register_tb_top
